/* File: common/tdac_pkg.sv */
package tdac_pkg;

	// ==========================================
	// register indices (byte address = 4 * index)
	localparam logic [7:0] IDX_CC0_LO = 8'hda;
	localparam logic [7:0] IDX_CC0_HI = 8'hdb;
	localparam logic [7:0] IDX_CC1_LO = 8'hdc;
	localparam logic [7:0] IDX_CC1_HI = 8'hdd;
	localparam logic [7:0] IDX_CC2_LO = 8'hde;
	localparam logic [7:0] IDX_CC2_HI = 8'hdf;
	localparam logic [7:0] IDX_CNT_LO = 8'he2;
	localparam logic [7:0] IDX_CNT_HI = 8'he3;
	localparam logic [7:0] IDX_CTL = 8'he4;
	localparam logic [7:0] IDX_CH0_CTL = 8'he5;
	localparam logic [7:0] IDX_CH1_CTL = 8'he6;
	localparam logic [7:0] IDX_CH2_CTL = 8'he7;
	localparam logic [7:0] IDX_IRQ_CFG = 8'he8;
	localparam logic [7:0] IDX_CLK_CFG = 8'he9;

	// ==========================================
	// field positions
	localparam int CTL_FLAG_LSB = 4;
	localparam int CTL_DIV_LSB = 2;
	localparam int CTL_MODE_LSB = 0;
	localparam int CH_MASK_BIT = 6;
	localparam int CH_CMP_LSB = 3;
	localparam int CH_SEL_BIT = 2;
	localparam int CH_CAP_LSB = 0;
	localparam int IRQ_GLOBAL_BIT = 0;
	localparam int IRQ_OVF_MASK_BIT = 1;
	localparam int SAMPLE_DROP = 2;

	// ==========================================
	// reset values and codes
	localparam logic [7:0] CH_CTL_RESET = 8'h40;
	localparam logic [1:0] IRQ_CFG_RESET = 2'h0;
	localparam logic [2:0] CLK_CFG_RESET = 3'h0;
	localparam logic [2:0] CMP_DSM = 3'h7;
	localparam logic [2:0] DSM_LAST_QUARTER = 3'h3;
	localparam logic [2:0] DSM_LAST_EIGHTH = 3'h7;
	localparam logic [15:0] CNT_FULL = 16'hffff;

	typedef enum logic [1:0] {
		MODE_SUSPEND = 2'b00,
		MODE_FREE = 2'b01,
		MODE_MODULO = 2'b10,
		MODE_UPDOWN = 2'b11
	} tdac_mode_t;

endpackage

/* File: design/tdac_dsm.sv */
// ==========================================
// second-order one-bit modulator with interpolator and shaper
module tdac_dsm
	import tdac_pkg::*;
	(
	input logic sys_clk,
	input logic rst_n,
	input logic enable,
	input logic step,
	input logic load,
	input logic signed [13:0] sample,
	input logic interp_en,
	input logic shaper_en,
	input logic [2:0] phase,
	input logic [2:0] phase_last,
	output logic bit_out
	);

	logic signed [13:0] prev;
	logic signed [13:0] cur;
	logic signed [31:0] acc;
	logic [15:0] steps;
	logic [4:0] shift;
	logic signed [19:0] int1;
	logic signed [23:0] int2;
	logic bit_q;

	// ceiling log2: keeps the ramp from overshooting the new sample
	function automatic logic [4:0] ceil_log2(input logic [15:0] n);
		logic [4:0] r;
		r = 5'h0;
		for (int i = 0; i < 16; i++) begin
			if ((17'h1 << i) < {1'h0, n}) begin
				r = 5'(i + 1);
			end
		end
		return r;
	endfunction

	// interpolated input: ramp from prev to cur over one sample period
	wire logic signed [14:0] diff = {cur[13], cur} - {prev[13], prev};
	wire logic signed [31:0] acc_sh = acc >>> shift;
	wire logic signed [15:0] x_ramp = {{2{prev[13]}}, prev} + acc_sh[15:0];
	wire logic signed [15:0] x_in = interp_en ? x_ramp : {{2{cur[13]}}, cur};
	// full-scale feedback of a 14-bit signed input
	wire logic signed [15:0] fb = bit_q ? 16'sh2000 : -16'sh2000;
	wire logic signed [19:0] err = 20'(x_in) - 20'(fb);
	wire logic signed [19:0] next_int1 = int1 + err;
	wire logic signed [23:0] next_int2 = int2 + 24'(next_int1) - 24'(fb);

	// sample pipeline and interpolation state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 14'h0;
			cur <= 14'h0;
			acc <= 32'h0;
			steps <= 16'h0;
			shift <= 5'h0;
		end else if (!enable) begin
			prev <= 14'h0;
			cur <= sample;
			acc <= 32'h0;
			steps <= 16'h0;
		end else if (load) begin
			prev <= cur;
			cur <= sample;
			acc <= 32'h0;
			shift <= ceil_log2(steps); // gain compensation
			steps <= 16'h0;
		end else if (step) begin
			acc <= acc + {{17{diff[14]}}, diff};
			steps <= steps + 16'h1;
		end
	end

	// two integrators, cleared while off so a start is clean
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			int1 <= 20'h0;
			int2 <= 24'h0;
			bit_q <= 1'h0;
		end else if (!enable) begin
			int1 <= 20'h0;
			int2 <= 24'h0;
			bit_q <= 1'h0;
		end else if (step) begin
			int1 <= next_int1;
			int2 <= next_int2;
			bit_q <= ~next_int2[23];
		end
	end

	// shaper gives one rise and one fall per bit, trading swing for symmetry
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_out <= 1'h0;
		end else if (!enable) begin
			bit_out <= 1'h0;
		end else if (shaper_en) begin
			bit_out <= bit_q ? (phase != phase_last) : (phase == 3'h0);
		end else begin
			bit_out <= bit_q;
		end
	end

endmodule

/* File: design/tdac_timer.sv */
module tdac_timer
	import tdac_pkg::*;
	#(
	parameter int ADDR_W = 12
	)
	(
	input logic sys_clk,
	input logic reset_n,
	input logic hsel,
	input logic [ADDR_W-1:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input logic [2:0] cap_pin,
	output logic [2:0] chan_out,
	output logic dma_req_chan0,
	output logic dma_req_chan1,
	output logic dma_req_chan2,
	output logic timer_irq
	);

	// ==========================================
	// reset release
	logic rst_meta;
	logic rst_n_q;

	// async assert, clocked release through two stages
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'h0;
			rst_n_q <= 1'h0;
		end else begin
			rst_meta <= 1'h1;
			rst_n_q <= rst_meta;
		end
	end

	// ==========================================
	// state
	logic [15:0] count_value;
	logic [7:0] cnt_hi_latch;
	logic count_down;
	logic [3:0] flags;
	logic [1:0] div_sel;
	tdac_mode_t mode;
	logic [7:0] chctl [3];
	logic [15:0] cc [3];
	logic [7:0] cc_stage [3];
	logic chan_level [3];
	logic [1:0] irq_cfg;
	logic [2:0] clk_cfg;
	logic [6:0] tick_cnt;
	logic [6:0] presc;
	logic [2:0] dsm_phase;
	logic [2:0] cap_meta;
	logic [2:0] cap_sync;
	logic [2:0] cap_prev;
	logic wr_pend;
	logic [7:0] wr_idx;
	logic [7:0] wr_data;
	logic dsm_bit;

	function automatic logic idx_is(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	// compare output action for one counter step
	function automatic logic out_next(input logic cur, input logic [2:0] act,
			input logic hit, input logic hit0, input logic zero,
			input logic dn, input logic ud);
		logic back;
		back = ud ? (hit && dn) : zero;
		case (act)
			3'h0: return hit ? 1'h1 : cur;
			3'h1: return hit ? 1'h0 : cur;
			3'h2: return hit ? ~cur : cur;
			3'h3: return (hit && !dn) ? 1'h1 : (back ? 1'h0 : cur);
			3'h4: return (hit && !dn) ? 1'h0 : (back ? 1'h1 : cur);
			3'h5: return hit ? 1'h1 : (hit0 ? 1'h0 : cur);
			3'h6: return hit ? 1'h0 : (hit0 ? 1'h1 : cur);
			default: return cur;
		endcase
	endfunction

	// ==========================================
	// bus slave: zero wait, always OKAY
	wire logic acc_take = hsel && htrans[1] && hready;
	wire logic [7:0] acc_idx = haddr[9:2];
	wire logic acc_in_map = (haddr[ADDR_W-1:10] == '0);
	wire logic rd_take = acc_take && !hwrite && acc_in_map;
	wire logic rd_cnt_lo = rd_take && idx_is(acc_idx, IDX_CNT_LO);
	wire logic w_cnt_lo = wr_pend && idx_is(wr_idx, IDX_CNT_LO);
	wire logic w_ctl = wr_pend && idx_is(wr_idx, IDX_CTL);
	wire logic w_irq = wr_pend && idx_is(wr_idx, IDX_IRQ_CFG);
	wire logic w_clk = wr_pend && idx_is(wr_idx, IDX_CLK_CFG);

	// read selection; unmapped words read zero
	wire logic [7:0] rd_val =
		!acc_in_map ? 8'h0 :
		idx_is(acc_idx, IDX_CNT_LO) ? count_value[7:0] :
		idx_is(acc_idx, IDX_CNT_HI) ? cnt_hi_latch :
		idx_is(acc_idx, IDX_CTL) ? {flags, div_sel, mode} :
		idx_is(acc_idx, IDX_CH0_CTL) ? chctl[0] :
		idx_is(acc_idx, IDX_CH1_CTL) ? chctl[1] :
		idx_is(acc_idx, IDX_CH2_CTL) ? chctl[2] :
		idx_is(acc_idx, IDX_CC0_LO) ? cc[0][7:0] :
		idx_is(acc_idx, IDX_CC0_HI) ? cc[0][15:8] :
		idx_is(acc_idx, IDX_CC1_LO) ? cc[1][7:0] :
		idx_is(acc_idx, IDX_CC1_HI) ? cc[1][15:8] :
		idx_is(acc_idx, IDX_CC2_LO) ? cc[2][7:0] :
		idx_is(acc_idx, IDX_CC2_HI) ? cc[2][15:8] :
		idx_is(acc_idx, IDX_IRQ_CFG) ? {6'h0, irq_cfg} :
		idx_is(acc_idx, IDX_CLK_CFG) ? {5'h0, clk_cfg} : 8'h0;

	// address phase captured; write lands in the data phase
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wr_pend <= 1'h0;
			wr_idx <= 8'h0;
			hrdata <= 32'h0;
			hreadyout <= 1'h0;
			hresp <= 1'h0;
		end else begin
			wr_pend <= acc_take && hwrite && acc_in_map;
			wr_idx <= acc_idx;
			hrdata <= rd_take ? {24'h0, rd_val} : 32'h0;
			hreadyout <= 1'h1;
			hresp <= 1'h0;
		end
	end
	assign wr_data = hwdata[7:0];

	// ==========================================
	// tick, prescaler and modulator phase
	wire logic [6:0] tick_mask = 7'h7f >> (3'h7 - clk_cfg);
	wire logic tick = &(tick_cnt | ~tick_mask);
	wire logic presc_hit = (div_sel == 2'h0) ? 1'h1 :
		(div_sel == 2'h1) ? &presc[2:0] :
		(div_sel == 2'h2) ? &presc[4:0] : &presc;
	wire logic dsm_on = (chctl[1][CH_CMP_LSB +: 3] == CMP_DSM);
	wire logic [2:0] dsm_last = chctl[1][CH_SEL_BIT] ? DSM_LAST_QUARTER : DSM_LAST_EIGHTH;
	wire logic dsm_step = tick && dsm_on && (dsm_phase == dsm_last);
	wire logic running = (mode != MODE_SUSPEND);
	wire logic cnt_en = tick && running && (dsm_on || presc_hit);

	// prescaler free-runs on ticks; a new select never restarts it
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tick_cnt <= 7'h0;
			presc <= 7'h0;
			dsm_phase <= 3'h0;
		end else begin
			tick_cnt <= tick_cnt + 7'h1;
			if (tick) begin
				presc <= presc + 7'h1;
			end
			if (!dsm_on) begin
				dsm_phase <= 3'h0;
			end else if (tick) begin
				dsm_phase <= (dsm_phase == dsm_last) ? 3'h0 : dsm_phase + 3'h1;
			end
		end
	end

	// ==========================================
	// counter
	wire logic ud = (mode == MODE_UPDOWN);
	wire logic [15:0] terminal = (mode == MODE_FREE) ? CNT_FULL : cc[0];
	wire logic at_term = (count_value == terminal);
	wire logic at_zero = (count_value == 16'h0);
	wire logic turn_zero = ud && count_down && at_zero;
	wire logic turn_top = ud && !count_down && (count_value >= cc[0]);
	wire logic ovf_evt = cnt_en && (ud ? turn_zero : at_term);
	wire logic [15:0] next_count =
		(!ud && at_term) ? 16'h0 :
		turn_top ? count_value - 16'h1 :
		(ud && count_down && !at_zero) ? count_value - 16'h1 :
		count_value + 16'h1;

	// count from the current value in any running mode
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			count_value <= 16'h0;
			count_down <= 1'h0;
			cnt_hi_latch <= 8'h0;
		end else begin
			if (w_cnt_lo) begin
				count_value <= 16'h0;
			end else if (cnt_en) begin
				count_value <= next_count;
			end
			if (!ud || w_cnt_lo) begin
				count_down <= 1'h0;
			end else if (cnt_en && (turn_top || turn_zero)) begin
				count_down <= turn_top;
			end
			if (rd_cnt_lo) begin
				cnt_hi_latch <= count_value[15:8];
			end
		end
	end

	// ==========================================
	// capture pins: two stages before edge detection
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cap_meta <= 3'h0;
			cap_sync <= 3'h0;
			cap_prev <= 3'h0;
		end else begin
			cap_meta <= cap_pin;
			cap_sync <= cap_meta;
			cap_prev <= cap_sync;
		end
	end

	// ==========================================
	// channels
	logic [2:0] cmp_evt;
	logic [2:0] cap_evt;
	logic [2:0] chan_flag_evt;
	wire logic hit0 = (count_value == cc[0]);

	for (genvar n = 0; n < 3; n++) begin : g_chan
		wire logic [7:0] ctl_idx = 8'(IDX_CH0_CTL + n);
		wire logic [7:0] lo_idx = 8'(IDX_CC0_LO + 2 * n);
		wire logic [7:0] hi_idx = 8'(IDX_CC0_LO + 2 * n + 1);
		wire logic is_cmp = chctl[n][CH_SEL_BIT];
		wire logic [1:0] edge_sel = chctl[n][CH_CAP_LSB +: 2];
		wire logic rise = cap_sync[n] && !cap_prev[n];
		wire logic fall = !cap_sync[n] && cap_prev[n];
		// channel 1 capture field is reused by the modulator
		wire logic cap_ok = running && !is_cmp && !(n == 1 && dsm_on);
		assign cap_evt[n] = cap_ok && ((edge_sel[0] && rise) || (edge_sel[1] && fall));
		assign cmp_evt[n] = cnt_en && is_cmp && (count_value == cc[n]);
		// in up/down, channel 0 flags the zero turn instead of its compare
		if (n == 0) begin : g_ud0
			assign chan_flag_evt[n] = cap_evt[n] ||
				(ud ? (is_cmp && ovf_evt) : cmp_evt[n]);
		end else begin : g_other
			assign chan_flag_evt[n] = cap_evt[n] || cmp_evt[n];
		end

		// low byte is staged until the high byte commits both
		always_ff @(posedge sys_clk or negedge rst_n_q) begin
			if (!rst_n_q) begin
				chctl[n] <= CH_CTL_RESET;
				cc[n] <= 16'h0;
				cc_stage[n] <= 8'h0;
			end else begin
				if (wr_pend && idx_is(wr_idx, ctl_idx)) begin
					chctl[n] <= wr_data;
				end
				if (wr_pend && idx_is(wr_idx, lo_idx)) begin
					cc_stage[n] <= wr_data;
				end
				if (wr_pend && idx_is(wr_idx, hi_idx)) begin
					cc[n] <= {wr_data, cc_stage[n]};
				end else if (cap_evt[n]) begin
					cc[n] <= count_value;
				end
			end
		end

		// compare action level, updated on counter steps
		always_ff @(posedge sys_clk or negedge rst_n_q) begin
			if (!rst_n_q) begin
				chan_level[n] <= 1'h0;
			end else if (cnt_en && is_cmp) begin
				chan_level[n] <= out_next(chan_level[n], chctl[n][CH_CMP_LSB +: 3],
					count_value == cc[n], hit0, at_zero, count_down, ud);
			end
		end
	end

	// ==========================================
	// modulator
	tdac_dsm u_dsm (
		.sys_clk(sys_clk),
		.rst_n(rst_n_q),
		.enable(dsm_on),
		.step(dsm_step),
		.load(ovf_evt),
		.sample(cc[1][15:SAMPLE_DROP]),
		.interp_en(!chctl[1][CH_CAP_LSB + 1]),
		.shaper_en(chctl[1][CH_CAP_LSB]),
		.phase(dsm_phase),
		.phase_last(dsm_last),
		.bit_out(dsm_bit)
	);

	// ==========================================
	// control, status and flags
	wire logic [3:0] flag_set = {chan_flag_evt, ovf_evt};
	wire logic [3:0] flag_keep = w_ctl ? wr_data[7:4] : 4'hf;
	wire logic [3:0] flag_mask = {chctl[2][CH_MASK_BIT], chctl[1][CH_MASK_BIT],
		chctl[0][CH_MASK_BIT], irq_cfg[IRQ_OVF_MASK_BIT]};

	// writing one leaves a flag; a same-cycle event beats the clear
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			flags <= 4'h0;
			div_sel <= 2'h0;
			mode <= MODE_SUSPEND;
			irq_cfg <= IRQ_CFG_RESET;
			clk_cfg <= CLK_CFG_RESET;
		end else begin
			flags <= (flags & flag_keep) | flag_set;
			if (w_ctl) begin
				div_sel <= wr_data[CTL_DIV_LSB +: 2];
				mode <= tdac_mode_t'(wr_data[CTL_MODE_LSB +: 2]);
			end
			if (w_irq) begin
				irq_cfg <= wr_data[1:0];
			end
			if (w_clk) begin
				clk_cfg <= wr_data[2:0];
			end
		end
	end

	// ==========================================
	// outputs, all registered
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			chan_out <= 3'h0;
			dma_req_chan0 <= 1'h0;
			dma_req_chan1 <= 1'h0;
			dma_req_chan2 <= 1'h0;
			timer_irq <= 1'h0;
		end else begin
			chan_out <= {chan_level[2], dsm_on ? dsm_bit : chan_level[1],
				chan_level[0]};
			dma_req_chan0 <= cmp_evt[0];
			dma_req_chan1 <= cmp_evt[1];
			dma_req_chan2 <= cmp_evt[2];
			timer_irq <= irq_cfg[IRQ_GLOBAL_BIT] && |(flags & flag_mask);
		end
	end

endmodule

/* File: verification/tdac_timer_sva.sv */
// ==========================================
// bus and pin relations seen from the timer's ports
module tdac_timer_sva
	import tdac_pkg::*;
	#(
	parameter int ADDR_W = 12
	)
	(
	input logic sys_clk,
	input logic reset_n,
	input logic hsel,
	input logic [ADDR_W-1:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [31:0] hwdata,
	input logic hready,
	input logic hreadyout,
	input logic hresp,
	input logic [31:0] hrdata,
	input logic timer_irq
	);
	logic wr_pend, rd_pend, irq_en;
	logic [9:0] wr_idx, rd_idx;
	logic [7:0] age;
	wire take = hsel && htrans[1] && hready;
	// ==========================================
	// shadow of the bus: pending phases, global enable, cycles since a clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			irq_en <= 1'b0;
			age <= 8'hff;
		end else begin
			wr_pend <= take && hwrite;
			rd_pend <= take && !hwrite;
			wr_idx <= haddr[11:2];
			rd_idx <= haddr[11:2];
			if (wr_pend && wr_idx == {2'b00, IDX_IRQ_CFG}) irq_en <= hwdata[IRQ_GLOBAL_BIT];
			// saturate so an old clear never looks recent
			if (wr_pend && wr_idx == {2'b00, IDX_CNT_LO}) age <= 8'h00;
			else if (age != 8'hff) age <= age + 8'h01;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	a_ready_start: assert property ($rose(reset_n) |-> !hreadyout [*3] ##1 hreadyout)
		else $error("ready not on third edge after reset");
	a_ready_hold: assert property (hreadyout |=> hreadyout)
		else $error("ready dropped");
	a_rdata_idle: assert property (!rd_pend |-> hrdata == 32'h0)
		else $error("read data outside a read");
	a_rdata_upper: assert property (rd_pend |-> hrdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_unmapped_zero: assert property (rd_pend && rd_idx[9:8] != 2'b00 |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_irq_gate: assert property (timer_irq |-> $past(irq_en))
		else $error("interrupt without global enable");
	a_cnt_cleared: assert property (rd_pend && rd_idx == {2'b00, IDX_CNT_LO} &&
		age != 8'h00 && age < 8'hc8 |-> hrdata[7:0] < age)
		else $error("counter not cleared by low write");
endmodule

/* File: verification/tdac_feeder.sv */
// ==========================================
// sample feeder: one outstanding request per channel 0 trigger
module tdac_feeder
	import tdac_pkg::*;
	(
	input logic sys_clk,
	input logic reset_n,
	input logic sample_req,
	input logic taken,
	output logic pending
	);
	// a trigger during service is merged, as a slow feeder would do
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pending <= 1'b0;
		end else if (sample_req) begin
			pending <= 1'b1;
		end else if (taken) begin
			pending <= 1'b0;
		end
	end
endmodule

/* File: verification/timer_dsm_audio_core_tb.sv */
module timer_dsm_audio_core_tb
	import tdac_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic wr; logic [9:0] idx; logic [7:0] d; logic [7:0] ridx;
		logic [7:0] exp;} tdac_row_t;
	typedef struct {logic [7:0] ctl; logic [15:0] smp; int lo; int hi; int mf;} tdac_mod_t;
	logic sys_clk = 1'b0;
	logic reset_n, hsel, hwrite, hreadyout, hresp, timer_irq, taken, pending;
	logic prev1 = 1'b0;
	logic dma0, dma1, dma2;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rd;
	logic [2:0] cap_pin, chan_out;
	int num_errors, n_checks, ones, flips, n_dma0, n_dma1, n_dma2, a, b, c;
	longint t_end;
	logic [7:0] mexp [4] = '{8'h00, 8'h21, 8'h32, 8'h33};
	tdac_row_t rows [7] = '{'{1'b0, 10'h0e3, 8'h00, IDX_CNT_HI, 8'h00},
		'{1'b0, 10'h0e4, 8'h00, IDX_CTL, 8'h00}, '{1'b0, 10'h0e6, 8'h00, IDX_CH1_CTL, 8'h40},
		'{1'b0, 10'h0e8, 8'h00, IDX_IRQ_CFG, 8'h00}, '{1'b1, 10'h0e5, 8'h44, IDX_CH0_CTL, 8'h44},
		'{1'b1, 10'h0e3, 8'h5a, IDX_CNT_HI, 8'h00}, '{1'b1, 10'h1e4, 8'h02, IDX_CTL, 8'h00}};
	tdac_mod_t mods [6] = '{'{8'h38, 16'h8000, 0, 60, 62}, '{8'h39, 16'h8000, 50, 430, 130},
		'{8'h3c, 16'h7ffc, 400, 480, 122}, '{8'h3d, 16'h7ffc, 100, 370, 250},
		'{8'h3a, 16'h0000, 170, 310, 62}, '{8'h3b, 16'h0003, 170, 310, 130}};
	tdac_timer #(.ADDR_W(12)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.cap_pin(cap_pin), .chan_out(chan_out), .dma_req_chan0(dma0), .dma_req_chan1(dma1),
		.dma_req_chan2(dma2), .timer_irq(timer_irq));
	tdac_feeder u_feed (.sys_clk(sys_clk), .reset_n(reset_n), .sample_req(dma0),
		.taken(taken), .pending(pending));
	always #5 sys_clk = ~sys_clk;
	// ==========================================
	// pin monitors; counters only grow, so windows are taken as differences
	always @(posedge sys_clk) begin
		if (chan_out[1] === 1'b1) ones <= ones + 1;
		if (chan_out[1] !== prev1) flips <= flips + 1;
		prev1 <= chan_out[1];
		if (dma0 === 1'b1) n_dma0 <= n_dma0 + 1;
		if (dma1 === 1'b1) n_dma1 <= n_dma1 + 1;
		if (dma2 === 1'b1) n_dma2 <= n_dma2 + 1;
	end
	// ==========================================
	// checking and bus tasks
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task conclude;
		if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// address phase held until ready, then data phase held until ready
	task xfer(input logic wr, input logic [9:0] idx, input logic [7:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {idx, 2'b00};
		hwrite <= wr;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		rd = hrdata;
	endtask
	task wr16(input logic [7:0] lo, input logic [15:0] v);
		xfer(1'b1, {2'b00, lo}, v[7:0]);
		xfer(1'b1, {2'b00, lo + 8'h01}, v[15:8]);
	endtask
	initial begin
		#300000;
		num_errors++;
		conclude();
	end
	// ==========================================
	// main sequence
	initial begin
		{num_errors, n_checks} = '0;
		{reset_n, hsel, hwrite, taken, htrans, haddr, hwdata, cap_pin} = '0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		foreach (rows[i]) begin
			if (rows[i].wr) xfer(1'b1, rows[i].idx, rows[i].d);
			xfer(1'b0, {2'b00, rows[i].ridx}, 8'h00);
			check(rd, {24'h0, rows[i].exp});
		end
		xfer(1'b0, 10'h2e4, 8'h00);
		check(rd, 32'h0);
		wr16(IDX_CC0_LO, 16'h0005);
		for (int m = 0; m < 4; m++) begin
			xfer(1'b1, {2'b00, IDX_CTL}, 8'h00);
			xfer(1'b1, {2'b00, IDX_CNT_LO}, 8'ha5);
			xfer(1'b1, {2'b00, IDX_CTL}, 8'(m));
			repeat (40) @(posedge sys_clk);
			xfer(1'b0, {2'b00, IDX_CTL}, 8'h00);
			check(rd, {24'h0, mexp[m]});
			xfer(1'b0, {2'b00, IDX_CNT_LO}, 8'h00);
			check(32'(rd > 32'h5), 32'(m == 1));
		end
		// slowest prescaler: it is not restarted, so at most one early slow step lands
		xfer(1'b1, {2'b00, IDX_CTL}, 8'h00);
		xfer(1'b1, {2'b00, IDX_CNT_LO}, 8'h00);
		xfer(1'b1, {2'b00, IDX_CTL}, 8'h0d);
		repeat (100) @(posedge sys_clk);
		xfer(1'b0, {2'b00, IDX_CNT_LO}, 8'h00);
		check(32'(rd < 32'h3), 32'h1);
		xfer(1'b1, {2'b00, IDX_CTL}, 8'h00);
		wr16(IDX_CC1_LO, 16'h0003);
		xfer(1'b1, {2'b00, IDX_CH1_CTL}, 8'h04);
		xfer(1'b1, {2'b00, IDX_CH2_CTL}, 8'h00);
		xfer(1'b1, {2'b00, IDX_CTL}, 8'h02);
		{a, b, c} = {n_dma0, n_dma1, n_dma2};
		repeat (60) @(posedge sys_clk);
		check(32'((n_dma0 - a) inside {[9:11]} && (n_dma1 - b) inside {[9:11]}), 32'h1);
		check(32'(n_dma2 - c), 32'h0);
		check(32'(chan_out), 32'h3);
		check(32'(timer_irq), 32'h0);
		xfer(1'b1, {2'b00, IDX_IRQ_CFG}, 8'h01);
		repeat (3) @(posedge sys_clk);
		check(32'(timer_irq), 32'h1);
		xfer(1'b1, {2'b00, IDX_CH0_CTL}, 8'h04);
		repeat (3) @(posedge sys_clk);
		check(32'(timer_irq), 32'h0);
		// a rising edge on the channel 2 pin raises its flag, nothing before it
		xfer(1'b1, {2'b00, IDX_CH2_CTL}, 8'h01);
		xfer(1'b1, {2'b00, IDX_CTL}, 8'h02);
		xfer(1'b0, {2'b00, IDX_CTL}, 8'h00);
		check(32'(rd[7]), 32'h0);
		cap_pin <= 3'b100;
		repeat (5) @(posedge sys_clk);
		xfer(1'b0, {2'b00, IDX_CTL}, 8'h00);
		check(32'(rd[7]), 32'h1);
		cap_pin <= 3'b000;
		// modulator bring-up in the safe order; slow prescaler must not matter
		xfer(1'b1, {2'b00, IDX_CTL}, 8'h00);
		xfer(1'b1, {2'b00, IDX_CNT_LO}, 8'h00);
		wr16(IDX_CC0_LO, 16'h0013);
		xfer(1'b1, {2'b00, IDX_CH0_CTL}, 8'h04);
		wr16(IDX_CC1_LO, 16'h0000);
		xfer(1'b1, {2'b00, IDX_CTL}, 8'h0e);
		foreach (mods[i]) begin
			xfer(1'b1, {2'b00, IDX_CH1_CTL}, 8'h04);
			wr16(IDX_CC1_LO, mods[i].smp);
			xfer(1'b1, {2'b00, IDX_CH1_CTL}, mods[i].ctl);
			{a, b, c} = {ones, flips, n_dma0};
			t_end = $time + 4800;
			while ($time < t_end) begin
				if (pending) begin
					taken <= 1'b1;
					@(posedge sys_clk);
					taken <= 1'b0;
					wr16(IDX_CC1_LO, mods[i].smp);
				end else begin
					@(posedge sys_clk);
				end
			end
			check(32'((ones - a) >= mods[i].lo && (ones - a) <= mods[i].hi), 32'h1);
			check(32'((flips - b) <= mods[i].mf), 32'h1);
			check(32'((n_dma0 - c) inside {[22:27]}), 32'h1);
		end
		// mid-run reset: outputs fall at once, registers return to reset values
		reset_n <= 1'b0;
		@(posedge sys_clk);
		check(hrdata, 32'h0);
		check(32'({hreadyout, chan_out, dma0, dma1, dma2, timer_irq}), 32'h0);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check(32'(chan_out), 32'h0);
		xfer(1'b0, {2'b00, IDX_CH1_CTL}, 8'h00);
		check(rd, 32'h40);
		xfer(1'b0, {2'b00, IDX_CTL}, 8'h00);
		check(rd, 32'h0);
		xfer(1'b0, {2'b00, IDX_CNT_LO}, 8'h00);
		check(rd, 32'h0);
		conclude();
	end
endmodule
bind tdac_timer tdac_timer_sva #(.ADDR_W(ADDR_W)) u_sva (.sys_clk(sys_clk),
	.reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .timer_irq(timer_irq));
